// ===== hdl/mitr_pkg.sv
package mitr_pkg;
   // ****************************************
   // Register offsets
   // ****************************************
   localparam logic [7:0] MITR_OFF_MOTION_X_LOW   = 8'h03;
   localparam logic [7:0] MITR_OFF_MOTION_Y_LOW   = 8'h04;
   localparam logic [7:0] MITR_OFF_MOTION_XY_HIGH = 8'h05;
   localparam logic [7:0] MITR_OFF_WHEEL_COUNT    = 8'h06;
   localparam logic [7:0] MITR_OFF_SURFACE_QUAL   = 8'h07;
   localparam logic [7:0] MITR_OFF_SHUTTER_HIGH   = 8'h08;
   localparam logic [7:0] MITR_OFF_SHUTTER_LOW    = 8'h09;
   localparam logic [7:0] MITR_OFF_PIXEL_PEAK     = 8'h0A;
   localparam logic [7:0] MITR_OFF_PIXEL_SUM_HIGH = 8'h0B;

   // ****************************************
   // Reset values and field limits
   // ****************************************
   localparam logic [7:0]  MITR_RST_BYTE         = 8'h00;
   localparam logic [15:0] MITR_RST_SHUTTER      = 16'h0032;
   localparam logic [7:0]  MITR_WHEEL_MAX        = 8'h7F;
   localparam logic [7:0]  MITR_WHEEL_MIN        = 8'h81;
   localparam logic [7:0]  MITR_SURFACE_QUALITY_MAX        = 8'h80;
   localparam int          MITR_DELTA_W          = 12;
   localparam int          MITR_SUM_W            = 17;
   localparam int          MITR_SUM_HI_BIT       = 15;
   localparam int          MITR_SUM_LO_BIT       = 8;
   localparam int          MITR_PIX_W            = 7;
endpackage

// ===== hdl/mitr_sat.sv
`timescale 1ns/1ps
// ****************************************
// Signed 8-bit saturation to -127..127
// ****************************************
module mitr_sat
   import mitr_pkg::*;
(
   // Raw input
   input  wire logic [7:0] raw,
   // Limited output
   output logic      [7:0] sat
);
   // -128 is the only code out of range
   always_comb begin
      if (raw == 8'h80) begin
         sat = MITR_WHEEL_MIN;
      end else begin
         sat = raw;
      end
   end
endmodule

// ===== hdl/mitr_regs.sv
`timescale 1ns/1ps
// Contract
// - Offset 0x03 shows low byte of last reported X delta.
// - Offset 0x04 shows low byte of last reported Y delta.
// - Offset 0x05 holds X upper nibble in 7:4, Y upper nibble 3:0.
// - Reading 0x04 or 0x05 without prior 0x03 read returns zero.
// - Deltas are twelve-bit two's complement at current resolution.
// - Wheel count at 0x06 is signed, limited to -127..127.
// - Surface feature count at 0x07 never exceeds 128.
// - Shutter open cycles as 16 bits at 0x08 high, 0x09 low.
// - Pixel peak at 0x0A with bit 7 always zero.
// - Seventeen-bit pixel sum, bits 15:8 shown at 0x0B.
// - X low byte holds delta bits 7:0, resets to zero.
// - Registers reached over USB, disabled on supply drop or bus reset.
module mitr_regs
   import mitr_pkg::*;
(
   // Clock and reset
   input  wire logic                      clk,
   input  wire logic                      rst_n,
   // USB bus reset and supply-good, from the same clock domain
   input  wire logic                      usb_bus_reset,
   input  wire logic                      supply_ok,
   // Register read port from USB request logic
   input  wire logic                      rd_en,
   input  wire logic [7:0]                rd_addr,
   output logic      [7:0]                rd_data,
   output logic                           rd_valid,
   // Motion report strobe and deltas
   input  wire logic                      report_load,
   input  wire logic [MITR_DELTA_W-1:0]   delta_x,
   input  wire logic [MITR_DELTA_W-1:0]   delta_y,
   input  wire logic [7:0]                wheel_in,
   // Frame statistics strobe and values
   input  wire logic                      frame_done,
   input  wire logic [7:0]                surface_quality_in,
   input  wire logic [15:0]               shutter_in,
   input  wire logic [MITR_PIX_W-1:0]     peak_in,
   input  wire logic [MITR_SUM_W-1:0]     sum_in
);

   // ****************************************
   // Stored values
   // ****************************************
   logic [MITR_DELTA_W-1:0] dx_r;
   logic [MITR_DELTA_W-1:0] dy_r;
   logic [7:0]              wheel_r;
   logic [7:0]              surface_quality_r;
   logic [15:0]             shut_r;
   logic [7:0]              shutter_time_low_hold_r;
   logic                    shut_held_r;
   logic [MITR_PIX_W-1:0]   peak_r;
   logic [7:0]              sum_hi_r;
   logic                    x_read_r;
   logic [7:0]              wheel_sat;
   logic                    regs_off;
   logic [7:0]              rd_data_nxt;
   logic                    hit_x_low;
   logic                    hit_shut_high;
   logic                    hit_shut_low;

   // ****************************************
   // Read hit decode
   // ****************************************
   // One place for the strobe-and-offset match behind every read side effect
   function automatic logic read_hit(
      input logic       en,
      input logic [7:0] addr,
      input logic [7:0] off
   );
      return en && (addr == off);
   endfunction

   // Side effects only on a real read strobe, never on a stray address
   assign hit_x_low     = read_hit(rd_en, rd_addr, MITR_OFF_MOTION_X_LOW);
   assign hit_shut_high = read_hit(rd_en, rd_addr, MITR_OFF_SHUTTER_HIGH);
   assign hit_shut_low  = read_hit(rd_en, rd_addr, MITR_OFF_SHUTTER_LOW);

   // ****************************************
   // Disable and wheel limit
   // ****************************************
   // Registers fall back to reset values while disabled
   // Supply drop and bus reset look alike here; both wipe the arming too
   assign regs_off = usb_bus_reset | ~supply_ok;

   mitr_sat u_sat (
      .raw (wheel_in),
      .sat (wheel_sat)
   );

   // ****************************************
   // Motion capture
   // ****************************************
   // Deltas are stored as-is; scaling is upstream
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         dx_r <= '0;
         dy_r <= '0;
      end else if (regs_off) begin
         dx_r <= '0;
         dy_r <= '0;
      end else if (report_load) begin
         dx_r <= delta_x;
         dy_r <= delta_y;
      end
   end

   // Wheel count taken with the same report as the deltas
   // The limiter has already folded -128 into -127
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         wheel_r <= MITR_RST_BYTE;
      end else if (regs_off) begin
         wheel_r <= MITR_RST_BYTE;
      end else if (report_load) begin
         wheel_r <= wheel_sat;
      end
   end

   // ****************************************
   // Coherent motion read arming
   // ****************************************
   // Low X read arms the Y and high reads; new report does not disarm
   // Limitation: a report landing between reads can still mix two samples
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         x_read_r <= 1'b0;
      end else if (regs_off) begin
         x_read_r <= 1'b0;
      end else if (hit_x_low) begin
         x_read_r <= 1'b1;
      end
   end

   // ****************************************
   // Frame statistics capture
   // ****************************************
   // Image figures, all taken on the end-of-frame strobe
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         surface_quality_r  <= MITR_RST_BYTE;
         peak_r   <= '0;
         sum_hi_r <= MITR_RST_BYTE;
      end else if (regs_off) begin
         surface_quality_r  <= MITR_RST_BYTE;
         peak_r   <= '0;
         sum_hi_r <= MITR_RST_BYTE;
      end else if (frame_done) begin
         // Clamp guards against a miscounting feature detector
         surface_quality_r  <= (surface_quality_in > MITR_SURFACE_QUALITY_MAX) ? MITR_SURFACE_QUALITY_MAX : surface_quality_in;
         peak_r   <= peak_in;
         sum_hi_r <= sum_in[MITR_SUM_HI_BIT:MITR_SUM_LO_BIT];
      end
   end

   // Shutter open time, counted in main-clock cycles upstream
   // Reset value is not zero, so the low byte reads a known figure at once
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         shut_r <= MITR_RST_SHUTTER;
      end else if (regs_off) begin
         shut_r <= MITR_RST_SHUTTER;
      end else if (frame_done) begin
         shut_r <= shutter_in;
      end
   end

   // ****************************************
   // Shutter pair hold
   // ****************************************
   // High-byte read freezes the low byte so a frame between reads can't split them
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         shutter_time_low_hold_r <= MITR_RST_BYTE;
         shut_held_r    <= 1'b0;
      end else if (regs_off) begin
         shutter_time_low_hold_r <= MITR_RST_BYTE;
         shut_held_r    <= 1'b0;
      end else if (hit_shut_high) begin
         shutter_time_low_hold_r <= shut_r[7:0];
         shut_held_r    <= 1'b1;
      end else if (hit_shut_low) begin
         shut_held_r    <= 1'b0;
      end
   end

   // ****************************************
   // Read decode
   // ****************************************
   // Unmapped offsets read zero
   // Y and high reads stay zero until the X low read has armed them
   always_comb begin
      rd_data_nxt = 8'h00;
      unique case (rd_addr)
         MITR_OFF_MOTION_X_LOW:   rd_data_nxt = dx_r[7:0];
         MITR_OFF_MOTION_Y_LOW:   rd_data_nxt = x_read_r ? dy_r[7:0] : 8'h00;
         MITR_OFF_MOTION_XY_HIGH: rd_data_nxt = x_read_r ?
                                  {dx_r[11:8], dy_r[11:8]} : 8'h00;
         MITR_OFF_WHEEL_COUNT:    rd_data_nxt = wheel_r;
         MITR_OFF_SURFACE_QUAL:   rd_data_nxt = surface_quality_r;
         MITR_OFF_SHUTTER_HIGH:   rd_data_nxt = shut_r[15:8];
         MITR_OFF_SHUTTER_LOW:    rd_data_nxt = shut_held_r ? shutter_time_low_hold_r
                                                            : shut_r[7:0];
         MITR_OFF_PIXEL_PEAK:     rd_data_nxt = {1'b0, peak_r};
         MITR_OFF_PIXEL_SUM_HIGH: rd_data_nxt = sum_hi_r;
         default:                 rd_data_nxt = 8'h00;
      endcase
   end

   // ****************************************
   // Read answer
   // ****************************************
   // Registered answer, one cycle after the request
   // Both outputs are flops so the port never shows decode glitches
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rd_data  <= 8'h00;
         rd_valid <= 1'b0;
      end else begin
         rd_valid <= rd_en;
         rd_data  <= (rd_en && !regs_off) ? rd_data_nxt : 8'h00;
      end
   end
endmodule

// ===== dv/mitr_chk.sv
`timescale 1ns/1ps
// ***
// Read checker
// ***
module mitr_chk
   import mitr_pkg::*;
(
   // Clock, reset, disables
   input  wire logic                    clk,
   input  wire logic                    rst_n,
   input  wire logic                    usb_bus_reset,
   input  wire logic                    supply_ok,
   // Read port and strobes
   input  wire logic                    rd_en,
   input  wire logic                    rd_valid,
   input  wire logic                    report_load,
   input  wire logic                    frame_done,
   input  wire logic [7:0]              rd_addr,
   input  wire logic [7:0]              rd_data,
   // Captured values
   input  wire logic [MITR_DELTA_W-1:0] delta_x,
   input  wire logic [MITR_SUM_W-1:0]   sum_in
);
   logic       en;
   logic       armed_r;
   logic [7:0] x_lo;
   logic [7:0] sum_hi;
   // Enable and watched fields
   assign en     = supply_ok && !usb_bus_reset;
   assign x_lo   = delta_x[7:0];
   assign sum_hi = sum_in[MITR_SUM_HI_BIT:MITR_SUM_LO_BIT];
   // Arming by an X low read, lost on disable as in the design
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) armed_r <= 1'b0;
      else if (!en) armed_r <= 1'b0;
      else if (rd_en && rd_addr == MITR_OFF_MOTION_X_LOW) armed_r <= 1'b1;
   end
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);
   a_read_answered: assert property (rd_en && en |=> rd_valid)
      else $error("read not answered");
   a_unarmed_zero: assert property (rd_en && !armed_r && (rd_addr == 8'h04 ||
      rd_addr == 8'h05) |=> rd_data == 8'h00) else $error("unarmed read not zero");
   a_wheel_range: assert property (rd_en && rd_addr == 8'h06 |=> rd_data != 8'h80)
      else $error("wheel out of range");
   a_surface_quality_limit: assert property (rd_en && rd_addr == 8'h07 |=> rd_data <= 8'h80)
      else $error("quality above limit");
   a_peak_bit7: assert property (rd_en && rd_addr == 8'h0A |=> !rd_data[7])
      else $error("peak bit 7 set");
   a_disabled_zero: assert property (rd_en && !en |=> rd_data == 8'h00)
      else $error("read while disabled not zero");
   a_sum_field: assert property (frame_done && en ##1 !frame_done && en ##1 rd_en && en
      && !frame_done && rd_addr == 8'h0B |=> rd_data == $past(sum_hi, 3))
      else $error("pixel sum field wrong");
   a_x_low_byte: assert property (report_load && en ##1 !report_load && en ##1 rd_en && en
      && !report_load && rd_addr == 8'h03 |=> rd_data == $past(x_lo, 3))
      else $error("x low byte wrong");
endmodule

// ===== dv/mitr_host.sv
`timescale 1ns/1ps
// ***
// Host side, one read at a time
// ***
module mitr_host (
   // Clock
   input  wire logic       clk,
   // Read request and answer
   output logic            rd_en,
   output logic      [7:0] rd_addr,
   input  wire logic [7:0] rd_data,
   input  wire logic       rd_valid
);
   initial begin
      rd_en = 1'b0;
      rd_addr = 8'hFF;
   end
   // Released address shows junk so a stale decode cannot pass
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(negedge clk) rd_en = 1'b1;
      rd_addr = a;
      // Answer stands only in the cycle after the request edge
      @(negedge clk) d = rd_valid ? rd_data : 8'hEE;
      rd_en = 1'b0;
      rd_addr = ~a;
   endtask
endmodule

// ===== dv/test_mitr_regs.sv
`timescale 1ns/1ps
module test_mitr_regs;
   logic clk = 1'b0, rst_n = 1'b0, usb_bus_reset = 1'b0, supply_ok = 1'b1;
   logic rd_en, rd_valid, report_load = 1'b0, frame_done = 1'b0;
   logic [7:0] rd_addr, rd_data, d, wheel_in = 8'h00, surface_quality_in = 8'h00;
   logic [11:0] delta_x = 12'h000, delta_y = 12'h000;
   logic [15:0] shutter_in = 16'h0000;
   logic [6:0] peak_in = 7'h00;
   logic [16:0] sum_in = 17'h00000;
   int err_total = 0, compares = 0, cycles = 0;
   // ***
   // Clock, design and host
   // ***
   always #12.5 clk = ~clk;
   mitr_regs uut (
      .clk           (clk),
      .rst_n         (rst_n),
      .usb_bus_reset (usb_bus_reset),
      .supply_ok     (supply_ok),
      .rd_en         (rd_en),
      .rd_addr       (rd_addr),
      .rd_data       (rd_data),
      .rd_valid      (rd_valid),
      .report_load   (report_load),
      .delta_x       (delta_x),
      .delta_y       (delta_y),
      .wheel_in      (wheel_in),
      .frame_done    (frame_done),
      .surface_quality_in      (surface_quality_in),
      .shutter_in    (shutter_in),
      .peak_in       (peak_in),
      .sum_in        (sum_in)
   );
   mitr_host host (
      .clk      (clk),
      .rd_en    (rd_en),
      .rd_addr  (rd_addr),
      .rd_data  (rd_data),
      .rd_valid (rd_valid)
   );
   task automatic chk(input logic [7:0] seen, exp);
      compares++;
      if (seen !== exp) begin
         err_total++;
         $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic rdc(input logic [7:0] a, exp);
      host.rd(a, d);
      chk(d, exp);
   endtask
   // One-cycle strobe on {usb_bus_reset, frame_done, report_load}
   task automatic pulse(input logic [2:0] sel);
      @(negedge clk) {usb_bus_reset, frame_done, report_load} = sel;
      @(negedge clk) {usb_bus_reset, frame_done, report_load} = 3'b000;
   endtask
   task automatic stop_test;
      if (err_total == 0 && compares > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask
   // Hang guard, far above the 70 or so cycles needed
   always @(posedge clk) begin
      cycles++;
      if (cycles == 3000) begin
         err_total++;
         stop_test;
      end
   end
   // Reset values, ordered reads, statistics, disables
   initial begin
      repeat (16) @(negedge clk);
      rst_n = 1'b1;
      for (int a = 4; a < 12; a++) rdc(8'(a), a == 9 ? 8'h32 : 8'h00);
      delta_x = 12'hA5C;
      delta_y = 12'h3E7;
      wheel_in = 8'h80;
      pulse(3'b001);
      rdc(8'h04, 8'h00);
      rdc(8'h05, 8'h00);
      pulse(3'b001);
      rdc(8'h03, 8'h5C);
      rdc(8'h04, 8'hE7);
      rdc(8'h05, 8'hA3);
      rdc(8'h06, 8'h81);
      surface_quality_in = 8'hFF;
      shutter_in = 16'h1234;
      peak_in = 7'h7F;
      sum_in = 17'h1ABCD;
      pulse(3'b010);
      rdc(8'h0B, 8'hAB);
      rdc(8'h08, 8'h12);
      shutter_in = 16'h5678;
      pulse(3'b010);
      rdc(8'h09, 8'h34);
      rdc(8'h09, 8'h78);
      rdc(8'h0A, 8'h7F);
      rdc(8'h07, 8'h80);
      supply_ok = 1'b0;
      rdc(8'h03, 8'h00);
      supply_ok = 1'b1;
      pulse(3'b100);
      rdc(8'h09, 8'h32);
      stop_test;
   end
endmodule
bind mitr_regs mitr_chk chk_i (
   .clk           (clk),
   .rst_n         (rst_n),
   .usb_bus_reset (usb_bus_reset),
   .supply_ok     (supply_ok),
   .rd_en         (rd_en),
   .rd_valid      (rd_valid),
   .report_load   (report_load),
   .frame_done    (frame_done),
   .rd_addr       (rd_addr),
   .rd_data       (rd_data),
   .delta_x       (delta_x),
   .sum_in        (sum_in)
);
